// *** design/pdmc_clk_div.sv ***
`timescale 1ns/1ns
`default_nettype none

// Produces a one-cycle enable every 2^sel cycles for sel 1 to 5, every 32 for sel 6 and 7; sel 0 means every cycle.
module pdmc_clk_div (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [2:0] sel,
  output var  logic       tick
);

  pdmc_pkg::pdmc_div_state_t s_q, s_d;

  // ========================================================================
  // Divider
  function automatic logic [4:0] div_mask(input logic [2:0] code);
    case (code)
      3'h1:    div_mask = 5'h01;
      3'h2:    div_mask = 5'h03;
      3'h3:    div_mask = 5'h07;
      3'h4:    div_mask = 5'h0F;
      3'h5:    div_mask = 5'h1F;
      default: div_mask = 5'h1F;
    endcase
  endfunction : div_mask

  // Terminal count on masked bits; zero select bypasses the divider
  always_comb begin
    s_d = s_q;
    s_d.cnt = s_q.cnt + 5'h01;
    if (sel == 3'h0) begin
      s_d.tick = 1'b1;
      s_d.cnt  = 5'h00;
    end else begin
      s_d.tick = ((s_q.cnt & div_mask(sel)) == div_mask(sel));
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule : pdmc_clk_div

`default_nettype wire

// *** design/pdmc_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "pdmc_params.svh"

module pdmc_top (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [7:0]            haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output var  logic [31:0]           hrdata,
  output var  logic                  hreadyout,
  output var  logic                  hresp,
  // Pins, active low
  input  wire logic                  reset_pin_n,
  input  wire logic                  manual_reset_pin_n,
  input  wire logic                  hw_standby_pin_n,
  // CPU side
  input  wire pdmc_pkg::pdmc_cpu_in_t cpu_in,
  output var  pdmc_pkg::pdmc_ctl_out_t ctl_out
);

  // ========================================================================
  // State
  typedef struct packed {
    logic [7:0]            stop_a;
    logic [7:0]            stop_b;
    logic [7:0]            stop_c;
    logic [7:0]            sby;
    logic [7:0]            lpw;
    logic [2:0]            sck;
    logic [23:0]           stop_eff;
    logic [2:0]            sck_eff;
    pdmc_pkg::pdmc_state_t st;
    logic [18:0]           wait_cnt;
    logic [2:0]            rst_sync;
    logic [2:0]            mrst_sync;
    logic [2:0]            hw_standby_pin_sync;
    logic                  rst_in_q;
    logic                  hw_standby_pin_in_q;
    logic                  dph_wr;
    logic                  dph_rd;
    logic [7:0]            dph_addr;
    logic [31:0]           rdata;
    pdmc_pkg::pdmc_ctl_out_t out;
  } pdmc_regs_t;

  pdmc_regs_t r_q, r_d;
  logic       div_tick;
  logic       any_reset;
  logic       irq_wake;
  logic       ext_wake;
  logic       addr_ok;

  // ========================================================================
  // Helpers
  function automatic logic [18:0] settle_count(input logic [2:0] code);
    case (code)
      3'h0:    settle_count = `PDMC_WAIT_0;
      3'h1:    settle_count = `PDMC_WAIT_1;
      3'h2:    settle_count = `PDMC_WAIT_2;
      3'h3:    settle_count = `PDMC_WAIT_3;
      3'h4:    settle_count = `PDMC_WAIT_4;
      default: settle_count = `PDMC_WAIT_5; // Reserved codes take the longest
    endcase
  endfunction : settle_count

  function automatic logic sync_level(input logic [2:0] s, input logic prev);
    // Level changes only when stages two and three agree
    sync_level = (s[1] == s[2]) ? s[2] : prev;
  endfunction : sync_level

  // Divided clock enable for both CPU and bus-master enables
  pdmc_clk_div u_div (
    .clk    (clk),
    .arst_n (arst_n),
    .sel    (r_q.sck_eff),
    .tick   (div_tick)
  );

  // ========================================================================
  // Wake qualification
  always_comb begin
    // IRQ must be enabled, not an engine source, and not CPU-masked
    ext_wake = cpu_in.nmi |
               ((|(cpu_in.irq_ext & cpu_in.irq_ext_en & ~cpu_in.irq_ext_dte))
                & ~cpu_in.irq_masked);
    irq_wake = cpu_in.nmi | (cpu_in.irq_enabled & ~cpu_in.irq_masked);
    any_reset = !r_q.rst_in_q | cpu_in.wdt_reset;
  end

  // Address decode
  always_comb begin
    if (haddr == `PDMC_OFS_STOP_A) begin
      addr_ok = 1'b1;
    end else if (haddr == `PDMC_OFS_STOP_B) begin
      addr_ok = 1'b1;
    end else if (haddr == `PDMC_OFS_STOP_C) begin
      addr_ok = 1'b1;
    end else if (haddr == `PDMC_OFS_SBY) begin
      addr_ok = 1'b1;
    end else if (haddr == `PDMC_OFS_LPW) begin
      addr_ok = 1'b1;
    end else if (haddr == `PDMC_OFS_SCK) begin
      addr_ok = 1'b1;
    end else if (haddr == `PDMC_OFS_STATUS) begin
      addr_ok = 1'b1;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // ========================================================================
  // Next state
  always_comb begin
    r_d = r_q;
    // Pin synchronisers, three stages
    // Each pin gets its own chain; gating two async pins first could glitch
    r_d.rst_sync  = {r_q.rst_sync[1:0], reset_pin_n};
    r_d.hw_standby_pin_sync = {r_q.hw_standby_pin_sync[1:0], hw_standby_pin_n};
    r_d.mrst_sync = {r_q.mrst_sync[1:0], manual_reset_pin_n};
    r_d.rst_in_q  = sync_level(r_q.rst_sync & r_q.mrst_sync, r_q.rst_in_q);
    r_d.hw_standby_pin_in_q = sync_level(r_q.hw_standby_pin_sync, r_q.hw_standby_pin_in_q);

    // Bus: address phase capture, single-cycle data phase
    r_d.dph_wr = hsel & hready & htrans[1] & hwrite & addr_ok;
    r_d.dph_rd = hsel & hready & htrans[1] & !hwrite;
    if (hsel & hready & htrans[1]) begin
      r_d.dph_addr = haddr;
    end
    if (r_q.dph_wr) begin
      // Plain storage; every bit writable except SBY bits 2:0 and LPW bits 6:1
      if (r_q.dph_addr == `PDMC_OFS_STOP_A) begin
        r_d.stop_a = hwdata[7:0];
      end else if (r_q.dph_addr == `PDMC_OFS_STOP_B) begin
        r_d.stop_b = hwdata[7:0];
      end else if (r_q.dph_addr == `PDMC_OFS_STOP_C) begin
        r_d.stop_c = hwdata[7:0];
      end else if (r_q.dph_addr == `PDMC_OFS_SBY) begin
        r_d.sby = {hwdata[7:3], 3'h0}; // Low three bits reserved
      end else if (r_q.dph_addr == `PDMC_OFS_LPW) begin
        r_d.lpw = {hwdata[7], 6'h00, hwdata[0]};
      end else if (r_q.dph_addr == `PDMC_OFS_SCK) begin
        r_d.sck = hwdata[2:0];
      end
    end

    // Read data sampled at address phase for the next cycle
    r_d.rdata = 32'h0000_0000;
    if (r_d.dph_rd) begin
      if (haddr == `PDMC_OFS_STOP_A) begin
        r_d.rdata = {24'h000000, r_q.stop_a};
      end else if (haddr == `PDMC_OFS_STOP_B) begin
        r_d.rdata = {24'h000000, r_q.stop_b};
      end else if (haddr == `PDMC_OFS_STOP_C) begin
        r_d.rdata = {24'h000000, r_q.stop_c};
      end else if (haddr == `PDMC_OFS_SBY) begin
        r_d.rdata = {24'h000000, r_q.sby};
      end else if (haddr == `PDMC_OFS_LPW) begin
        r_d.rdata = {24'h000000, r_q.lpw};
      end else if (haddr == `PDMC_OFS_SCK) begin
        r_d.rdata = {29'h00000000, r_q.sck};
      end else if (haddr == `PDMC_OFS_STATUS) begin
        r_d.rdata = {27'h0000000, r_q.st};
      end
    end

    // Written stops and clock select take effect only at a bus cycle end
    if (cpu_in.bus_cycle_end) begin
      r_d.stop_eff = {r_q.stop_c, r_q.stop_b, r_q.stop_a};
      r_d.sck_eff  = r_q.sck;
    end

    // Power state machine
    case (r_q.st)
      pdmc_pkg::PDMC_ST_RUN: begin
        if (cpu_in.sleep_req && !r_q.lpw[`PDMC_LPW_LOW_SPEED_ON_BIT]) begin
          if (!r_q.sby[`PDMC_SBY_STANDBY_SELECT_BIT]) begin
            r_d.st = pdmc_pkg::PDMC_ST_SLEEP;
          end else if (!cpu_in.watch_sel) begin
            r_d.st = pdmc_pkg::PDMC_ST_STANDBY_SELECT;
          end
        end
      end
      pdmc_pkg::PDMC_ST_SLEEP: begin
        if (irq_wake) begin
          r_d.st = pdmc_pkg::PDMC_ST_RUN;
        end
      end
      pdmc_pkg::PDMC_ST_STANDBY_SELECT: begin
        if (ext_wake) begin
          r_d.st       = pdmc_pkg::PDMC_ST_WAKE;
          r_d.wait_cnt = settle_count(r_q.sby[6:4]);
        end
      end
      pdmc_pkg::PDMC_ST_WAKE: begin
        if (r_q.wait_cnt <= 19'd1) begin
          r_d.st = pdmc_pkg::PDMC_ST_RUN;
        end else begin
          r_d.wait_cnt = r_q.wait_cnt - 19'd1;
        end
      end
      pdmc_pkg::PDMC_ST_RESET: begin
        if (r_q.rst_in_q && !cpu_in.wdt_reset) begin
          r_d.st = pdmc_pkg::PDMC_ST_RUN;
        end
      end
      default: r_d.st = pdmc_pkg::PDMC_ST_RESET;
    endcase

    // Reset pins override every state, clocks restart at once
    if (any_reset || !r_q.hw_standby_pin_in_q) begin
      r_d.st       = pdmc_pkg::PDMC_ST_RESET;
      r_d.sck      = 3'h0;
      r_d.sck_eff  = 3'h0;
      r_d.wait_cnt = 19'd0;
    end
    if (!r_q.hw_standby_pin_in_q) begin
      // Hardware standby puts every control back to reset
      r_d.stop_a   = `PDMC_RST_STOP_A;
      r_d.stop_b   = `PDMC_RST_STOP_B;
      r_d.stop_c   = `PDMC_RST_STOP_C;
      r_d.sby      = `PDMC_RST_SBY;
      r_d.lpw      = 8'h00;
      r_d.stop_eff = {`PDMC_RST_STOP_C, `PDMC_RST_STOP_B, `PDMC_RST_STOP_A};
    end

    // Outputs from state
    r_d.out.medium_speed  = (r_q.sck_eff != 3'h0);
    r_d.out.cpu_clk_en    = (r_q.st == pdmc_pkg::PDMC_ST_RUN) & div_tick;
    r_d.out.master_clk_en = (r_q.st != pdmc_pkg::PDMC_ST_STANDBY_SELECT) &
                            (r_q.st != pdmc_pkg::PDMC_ST_WAKE) & div_tick;
    if ((r_q.st == pdmc_pkg::PDMC_ST_STANDBY_SELECT) || (r_q.st == pdmc_pkg::PDMC_ST_WAKE)) begin
      r_d.out.module_stop = 24'hFFFFFF;
    end else begin
      r_d.out.module_stop = r_q.stop_eff;
    end
    r_d.out.osc_run     = (r_q.st != pdmc_pkg::PDMC_ST_STANDBY_SELECT);
    r_d.out.irq_start   = (r_q.st == pdmc_pkg::PDMC_ST_WAKE) &&
                          (r_d.st == pdmc_pkg::PDMC_ST_RUN) ||
                          (r_q.st == pdmc_pkg::PDMC_ST_SLEEP) &&
                          (r_d.st == pdmc_pkg::PDMC_ST_RUN);
    r_d.out.reset_hold  = (r_q.st == pdmc_pkg::PDMC_ST_RESET);
    r_d.out.reset_start = (r_q.st == pdmc_pkg::PDMC_ST_RESET) &&
                          (r_d.st == pdmc_pkg::PDMC_ST_RUN);
    r_d.out.hw_standby  = !r_q.hw_standby_pin_in_q;
    r_d.out.port_retain = r_q.sby[`PDMC_SBY_OPE_BIT];
  end

  // ========================================================================
  // Registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r_q           <= '0;
      r_q.stop_a    <= `PDMC_RST_STOP_A;
      r_q.stop_b    <= `PDMC_RST_STOP_B;
      r_q.stop_c    <= `PDMC_RST_STOP_C;
      r_q.sby       <= `PDMC_RST_SBY;
      r_q.stop_eff  <= {`PDMC_RST_STOP_C, `PDMC_RST_STOP_B, `PDMC_RST_STOP_A};
      r_q.st        <= pdmc_pkg::PDMC_ST_RESET;
      r_q.rst_sync  <= 3'h0;
      r_q.hw_standby_pin_sync <= 3'h7;
      r_q.hw_standby_pin_in_q <= 1'b1;
      r_q.out.module_stop <= {`PDMC_RST_STOP_C, `PDMC_RST_STOP_B, `PDMC_RST_STOP_A};
      r_q.out.reset_hold  <= 1'b1;
      r_q.out.osc_run     <= 1'b1;
      r_q.out.port_retain <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // Bus answers: zero wait, always OKAY
  assign hrdata    = r_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ctl_out   = r_q.out;

endmodule : pdmc_top

`default_nettype wire

// *** dv/pdmc_cpu_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// CPU side: bus cycles of four states, wake sources as software sets them
module pdmc_cpu_model (
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic                   bus_run,
  input  wire pdmc_pkg::pdmc_cpu_in_t req,
  output var  pdmc_pkg::pdmc_cpu_in_t cpu_in
);
  logic [1:0] cnt_q;
  // Free-running state counter of the current bus cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) cnt_q <= 2'h0;
    else cnt_q <= cnt_q + 2'h1;
  end
  // Enables and watch select come from software; stalls suppress the end strobe
  always_comb begin
    cpu_in = req;
    cpu_in.bus_cycle_end = bus_run && (cnt_q == 2'h3);
  end
endmodule : pdmc_cpu_model
`default_nettype wire

// *** dv/pdmc_top_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Port-level checker for the power-mode block
module pdmc_top_checker (
  input wire logic                    clk,
  input wire logic                    arst_n,
  input wire logic                    hsel,
  input wire logic [7:0]              haddr,
  input wire logic [1:0]              htrans,
  input wire logic                    hwrite,
  input wire logic [2:0]              hsize,
  input wire logic [31:0]             hwdata,
  input wire logic                    hready,
  input wire logic [31:0]             hrdata,
  input wire logic                    hreadyout,
  input wire logic                    hresp,
  input wire logic                    reset_pin_n,
  input wire logic                    manual_reset_pin_n,
  input wire logic                    hw_standby_pin_n,
  input wire pdmc_pkg::pdmc_cpu_in_t  cpu_in,
  input wire pdmc_pkg::pdmc_ctl_out_t ctl_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [19:0] wait_q;
  logic        sby_q;
  // Settle time since the oscillator restarted; saturates so it never wraps
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_q <= 20'h00000;
      sby_q  <= 1'b0;
    end else begin
      if (!ctl_out.osc_run) sby_q <= 1'b1;
      else if (ctl_out.irq_start || ctl_out.reset_hold) sby_q <= 1'b0;
      if (!ctl_out.osc_run) wait_q <= 20'h00000;
      else if (wait_q != 20'hFFFFF) wait_q <= wait_q + 20'h00001;
    end
  end
  // ========================================================================
  // Sequences and properties
  sequence s_quiet;
    (hw_standby_pin_n && reset_pin_n && manual_reset_pin_n && !cpu_in.bus_cycle_end)[*3];
  endsequence
  sequence s_res_low;
    (!reset_pin_n)[*8];
  endsequence
  sequence s_hws_low;
    (!hw_standby_pin_n)[*6];
  endsequence
  property p_stop_hold;
    s_quiet |=> $stable(ctl_out.module_stop) || $fell(ctl_out.osc_run) ||
                $past(ctl_out.irq_start);
  endproperty
  property p_read_idle;
    hrdata != 32'h00000000 |-> $past(hsel && hready && htrans[1] && !hwrite);
  endproperty
  property p_stop_gate;
    !ctl_out.osc_run && $past(!ctl_out.osc_run) |-> !ctl_out.cpu_clk_en && !ctl_out.master_clk_en;
  endproperty
  property p_osc_restart;
    !ctl_out.osc_run && !reset_pin_n |-> ##[1:8] ctl_out.osc_run;
  endproperty
  property p_reset_hold;
    s_res_low |-> ctl_out.reset_hold;
  endproperty
  property p_reset_start;
    ctl_out.reset_start |-> $past(ctl_out.reset_hold) && reset_pin_n && manual_reset_pin_n;
  endproperty
  property p_irq_pulse;
    ctl_out.irq_start |=> !ctl_out.irq_start;
  endproperty
  property p_settle;
    ctl_out.irq_start && sby_q |-> wait_q >= 20'h01FFE && ctl_out.osc_run;
  endproperty
  property p_hw_standby;
    s_hws_low |-> ctl_out.hw_standby;
  endproperty
  property p_stop_reset;
    $rose(arst_n) |-> ctl_out.module_stop == 24'hFFFF3F;
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("module stop moved without bus cycle end");
  a_read_idle: assert property (p_read_idle)
    else $error("read data outside a read data phase");
  a_stop_gate: assert property (p_stop_gate)
    else $error("clock enables running in standby");
  a_osc_restart: assert property (p_osc_restart)
    else $error("reset pin did not restart oscillator");
  a_reset_hold: assert property (p_reset_hold)
    else $error("reset pin low without reset hold");
  a_reset_start: assert property (p_reset_start)
    else $error("reset start without prior hold");
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("interrupt start longer than one cycle");
  a_settle: assert property (p_settle)
    else $error("standby wake shorter than settle count");
  a_hw_standby: assert property (p_hw_standby)
    else $error("standby pin low without hardware standby");
  a_stop_reset: assert property (p_stop_reset)
    else $error("module stop reset value wrong");
endmodule : pdmc_top_checker

bind pdmc_top pdmc_top_checker u_chk (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .reset_pin_n(reset_pin_n),
  .manual_reset_pin_n(manual_reset_pin_n), .hw_standby_pin_n(hw_standby_pin_n),
  .cpu_in(cpu_in), .ctl_out(ctl_out));
`default_nettype wire

// *** dv/tb_power_down_mode_control.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_power_down_mode_control;
  logic clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, bus_run = 1'b1;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000, hrdata, rd;
  logic hreadyout, hresp, reset_pin_n = 1'b1, mrst_n = 1'b1, hws_n = 1'b1;
  pdmc_pkg::pdmc_cpu_in_t req = '0, cpu_in;
  pdmc_pkg::pdmc_ctl_out_t ctl_out;
  int failures = 0, n_tests = 0, n, m;
  // ========================================================================
  // Clock, device and far side
  always #2 clk = ~clk;
  pdmc_top u_dut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .reset_pin_n(reset_pin_n),
    .manual_reset_pin_n(mrst_n), .hw_standby_pin_n(hws_n), .cpu_in(cpu_in), .ctl_out(ctl_out));
  pdmc_cpu_model u_cpu (.clk(clk), .arst_n(arst_n), .bus_run(bus_run), .req(req),
    .cpu_in(cpu_in));
  // ========================================================================
  // Shared tasks
  task automatic summarize;
    if (failures == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Single word transfer; waits on ready in both phases
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    chk(rd, e);
  endtask : rdc
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc
  task automatic sleep_now;
    @(posedge clk); req.sleep_req <= 1'b1;
    @(posedge clk); req.sleep_req <= 1'b0;
    cyc(6);
  endtask : sleep_now
  // Enables seen over 64 system clocks
  task automatic count_en;
    n = 0; m = 0;
    repeat (64) begin
      @(negedge clk);
      n += ctl_out.cpu_clk_en;
      m += ctl_out.master_clk_en;
    end
  endtask : count_en
  task automatic wait_irq(input int lim);
    n = 0;
    while (ctl_out.irq_start !== 1'b1 && n < lim) begin @(negedge clk); n++; end
  endtask : wait_irq
  // ========================================================================
  // Scenarios
  task automatic t_regs;
    rdc(8'h00, 32'h3F);
    rdc(8'h04, 32'hFF);
    rdc(8'h08, 32'hFF);
    chk(ctl_out.module_stop, 24'hFFFF3F);
    bus_run = 1'b0; // Bus cycle stalled: new stop bits must wait
    bus(1'b1, 8'h00, 32'h4D); bus(1'b1, 8'h04, 32'h17); bus(1'b1, 8'h08, 32'hA7);
    rdc(8'h00, 32'h4D);
    rdc(8'h04, 32'h17);
    rdc(8'h08, 32'hA7);
    rdc(8'h1C, 32'h00);
    chk(ctl_out.module_stop, 24'hFFFF3F);
    bus_run = 1'b1; cyc(8);
    chk(ctl_out.module_stop, 24'hA7174D);
  endtask : t_regs
  task automatic t_medium;
    for (int s = 1; s <= 5; s++) begin
      bus(1'b1, 8'h14, 32'(s)); cyc(8); count_en;
      chk(n, 64 >> s);
      chk(m, 64 >> s);
      chk(ctl_out.medium_speed, 1'b1);
    end
    bus(1'b1, 8'h14, 32'h0); cyc(8); count_en;
    chk(ctl_out.medium_speed, 1'b0);
    chk(n, 64);
  endtask : t_medium
  task automatic t_sleep;
    bus(1'b1, 8'h14, 32'h2); cyc(8); sleep_now;
    rdc(8'h18, 32'h2);
    chk(ctl_out.osc_run, 1'b1);
    req.irq_enabled <= 1'b1; req.irq_masked <= 1'b1; cyc(10);
    rdc(8'h18, 32'h2);
    req.irq_masked <= 1'b0; wait_irq(20);
    chk(ctl_out.irq_start, 1'b1);
    req.irq_enabled <= 1'b0; cyc(4);
    chk(ctl_out.medium_speed, 1'b1);
    bus(1'b1, 8'h14, 32'h0); cyc(8);
  endtask : t_sleep
  task automatic t_standby;
    bus(1'b1, 8'h0C, 32'h88); sleep_now;
    chk(ctl_out.osc_run, 1'b0);
    chk(ctl_out.cpu_clk_en, 1'b0);
    req.irq_ext <= 8'h01; req.irq_ext_en <= 8'h01; req.irq_ext_dte <= 8'h01; cyc(20);
    chk(ctl_out.osc_run, 1'b0);
    req.irq_ext <= 8'h00; req.nmi <= 1'b1; wait_irq(9000);
    req.nmi <= 1'b0;
    chk(n >= 8190 && n <= 8200, 1'b1);
    chk(ctl_out.osc_run, 1'b1);
    rdc(8'h0C, 32'h88);
  endtask : t_standby
  task automatic t_pins;
    sleep_now;
    @(posedge clk); reset_pin_n <= 1'b0; cyc(8);
    chk(ctl_out.osc_run, 1'b1);
    chk(ctl_out.reset_hold, 1'b1);
    @(posedge clk); reset_pin_n <= 1'b1;
    n = 0;
    while (ctl_out.reset_start !== 1'b1 && n < 20) begin @(negedge clk); n++; end
    chk(ctl_out.reset_start, 1'b1);
    cyc(8); bus(1'b1, 8'h14, 32'h1); cyc(8);
    chk(ctl_out.medium_speed, 1'b1);
    req.wdt_reset <= 1'b1; cyc(2); req.wdt_reset <= 1'b0; cyc(10);
    chk(ctl_out.medium_speed, 1'b0);
    @(posedge clk); hws_n <= 1'b0; cyc(8);
    chk(ctl_out.hw_standby, 1'b1);
    chk(ctl_out.module_stop, 24'hFFFF3F);
    @(posedge clk); hws_n <= 1'b1; cyc(10);
  endtask : t_pins
  // ========================================================================
  // Main sequence and hang guard
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    cyc(8);
    t_regs; t_medium; t_sleep; t_standby; t_pins;
    summarize;
  end
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    summarize;
  end
endmodule : tb_power_down_mode_control
`default_nettype wire

// *** pkg/pdmc_params.svh ***
`ifndef PDMC_PARAMS_SVH
`define PDMC_PARAMS_SVH

// ==========================================================================
// Register byte addresses
`define PDMC_OFS_STOP_A      8'h00
`define PDMC_OFS_STOP_B      8'h04
`define PDMC_OFS_STOP_C      8'h08
`define PDMC_OFS_SBY         8'h0C
`define PDMC_OFS_LPW         8'h10
`define PDMC_OFS_SCK         8'h14
`define PDMC_OFS_STATUS      8'h18

// ==========================================================================
// Reset values
`define PDMC_RST_STOP_A      8'h3F
`define PDMC_RST_STOP_B      8'hFF
`define PDMC_RST_STOP_C      8'hFF
`define PDMC_RST_SBY         8'h08

// ==========================================================================
// Field positions
`define PDMC_SBY_STANDBY_SELECT_BIT    7
`define PDMC_SBY_STS_LSB     4
`define PDMC_SBY_OPE_BIT     3
`define PDMC_LPW_LOW_SPEED_ON_BIT    7
`define PDMC_LPW_PSS_BIT     0

// ==========================================================================
// Settling wait counts in states, codes 000 to 101
`define PDMC_WAIT_0          19'd8192
`define PDMC_WAIT_1          19'd16384
`define PDMC_WAIT_2          19'd32768
`define PDMC_WAIT_3          19'd65536
`define PDMC_WAIT_4          19'd131072
`define PDMC_WAIT_5          19'd262144

`endif

// *** pkg/pdmc_pkg.sv ***
package pdmc_pkg;

  // ========================================================================
  // Operating states, one-hot
  typedef enum logic [4:0] {
    PDMC_ST_RUN   = 5'b00001,
    PDMC_ST_SLEEP = 5'b00010,
    PDMC_ST_STANDBY_SELECT  = 5'b00100,
    PDMC_ST_WAKE  = 5'b01000,
    PDMC_ST_RESET = 5'b10000
  } pdmc_state_t;

  // Wake and reset sources as seen by the block
  typedef struct packed {
    logic       sleep_req;
    logic       irq_enabled;
    logic       irq_masked;
    logic       nmi;
    logic [7:0] irq_ext;
    logic [7:0] irq_ext_en;
    logic [7:0] irq_ext_dte;
    logic       wdt_reset;
    logic       bus_cycle_end;
    logic       watch_sel;
  } pdmc_cpu_in_t;

  // Clock gates and mode flags toward the CPU and peripherals
  typedef struct packed {
    logic        cpu_clk_en;
    logic        master_clk_en;
    logic [23:0] module_stop;
    logic        osc_run;
    logic        irq_start;
    logic        reset_hold;
    logic        reset_start;
    logic        hw_standby;
    logic        medium_speed;
    logic        port_retain;
  } pdmc_ctl_out_t;

  // Divider and gate helper state
  typedef struct packed {
    logic [4:0] cnt;
    logic       tick;
  } pdmc_div_state_t;

endpackage : pdmc_pkg
